// File: verilog/cfh_host.v
// Purpose: Host controller driving a storage card's strobes and DMA pins
// Assumes: 10 MHz ref_clk; all card pins arrive asynchronously
// Notes:   Pin states advance on a divider tick, one strobe width apart, except at command accept, DMA ack, stop and Ultra DMA read ready
`timescale 1ns/1ps
`default_nettype none
`include "cfh_regs.vh"

// Notes on behaviour
// R1: Card leaves DMA request undriven when not selected.
// R2: During DMA both chip selects stay negated; transfers are 16 bits.
// R3: Host without DMA hardware ignores DMA request; DMA is reported unsupported.
// R4: In I/O mode card drives read data while I/O read is low.
// R5: In True IDE outside Ultra DMA, I/O read acts as in I/O mode.
// R6: Ultra DMA read: host asserts ready on read line, negates it to pause.
// R7: Ultra DMA write: card latches a word on both host strobe edges.
// R8: Host pauses data-out by making no strobe edges; card waits.
// R9: I/O write data is captured on the rising, trailing strobe edge.
// R10: Write line is negated before Ultra DMA begins; else acts as strobe.
// R11: Asserting stop on the write line ends the Ultra DMA burst.
// R12: Memory mode: card returns data while output enable is low.
// R13: I/O mode: output enable used only for CIS and configuration reads.
// R14: Host grounds output enable to select True IDE mode.
// R15: Memory mode: ready pin high when card can take a transfer.
// R16: Ready low after power-up or reset; host makes no access meanwhile.
// R17: Card disables reset input that is open or held from power-up.
// R18: I/O mode interrupt is active low on ready, pulse or level.
// R19: True IDE interrupt is active high on the ready pin.
// R20: Card holds DMA request until host acknowledges, then may reassert.
// R21: Pin functions follow the mode; unused strobes are ignored.
module cfh_host #(
  parameter DMA_EN = 1,
  parameter FIFO_D = 8
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // Mode selection
  input  wire [1:0]  mode,
  // Command port
  input  wire        cmdValid,
  output wire        cmdReady,
  input  wire [2:0]  cmdOp,
  input  wire [15:0] cmdWrData,
  input  wire [7:0]  cmdLen,
  output reg         cmdErr_reg,
  // Ultra DMA write stream
  input  wire        wrValid,
  output wire        wrReady,
  input  wire [15:0] wrData,
  // Read data
  output reg         rdValid_reg,
  input  wire        rdReady,
  output reg  [15:0] rdData_reg,
  // Status
  output wire        busy,
  output wire        cardReady,
  output wire        cardIrq,
  // Card pins
  output reg  [1:0]  csN_reg,
  output reg         iordN_reg,
  output reg         iowrN_reg,
  output wire        oeN,
  output reg         dmackN_reg,
  input  wire [15:0] dataIn,
  output reg  [15:0] dataOut_reg,
  output reg         dataOeN_reg,
  input  wire        readyPin,
  input  wire        dmarqPin,
  input  wire        iordyPin
);
  localparam S_INIT  = 3'h0;
  localparam S_IDLE  = 3'h1;
  localparam S_STB   = 3'h2;
  localparam S_TRAIL = 3'h3;
  localparam S_DREQ  = 3'h4;
  localparam S_URD   = 3'h5;
  localparam S_UWR   = 3'h6;
  localparam S_STOP  = 3'h7;
  localparam integer STB_CYC = `CFH_STB_CYC;

  reg  [2:0]  state_reg;
  reg  [2:0]  op_reg;
  reg  [7:0]  cnt_reg;
  reg  [3:0]  tick_reg;
  reg         phase_reg;
  reg         oeN_reg;
  reg         ackd_reg;
  reg  [18:0] syncA_reg;
  reg  [18:0] syncB_reg;
  reg         iordyPrev_reg;
  wire        tick;
  wire        readyS;
  wire        dmarqS;
  wire        iordyS;
  wire [15:0] dataS;
  wire        fifoValid;
  wire [15:0] fifoData;
  wire        fifoPop;
  wire        udCapture;
  wire        legal;

  // R3 R21 legal op per mode; DMA_EN=0 means no DMA hardware
  function opLegal;
    input [2:0] op;
    input [1:0] md;
    begin
      case (op)
        `CFH_OP_OERD: opLegal = (md == `CFH_MODE_MEM) || (md == `CFH_MODE_IO);
        `CFH_OP_IORD,
        `CFH_OP_IOWR: opLegal = (md == `CFH_MODE_IO) || (md == `CFH_MODE_IDE);
        `CFH_OP_UDRD,
        `CFH_OP_UDWR: opLegal = (md == `CFH_MODE_IDE) && (DMA_EN != 0);
        default:      opLegal = 1'b0;
      endcase
    end
  endfunction

  // Two-stage synchronisers on every card input
  always @(posedge ref_clk) begin
    syncA_reg <= {iordyPin, dmarqPin, readyPin, dataIn};
    syncB_reg <= syncA_reg;
  end
  assign dataS  = syncB_reg[15:0];
  assign readyS = syncB_reg[16];
  assign dmarqS = syncB_reg[17];
  assign iordyS = syncB_reg[18];

  // Divider tick paces every pin step except command accept, DMA ack, stop and Ultra DMA read ready
  always @(posedge ref_clk) begin
    if (srst || state_reg == S_IDLE || tick) begin
      tick_reg <= 4'h0;
    end else begin
      tick_reg <= tick_reg + 4'h1;
    end
  end
  assign tick = (tick_reg == STB_CYC[3:0] - 4'h1);

  // R18 R19 interrupt polarity per mode
  assign cardIrq   = (mode == `CFH_MODE_IO)  ? ~readyS :
                     (mode == `CFH_MODE_IDE) ?  readyS : 1'b0;
  // R15 ready only meaningful in memory mode
  assign cardReady = (mode == `CFH_MODE_MEM) & readyS;
  // R14 output enable grounded in True IDE
  assign oeN       = (mode == `CFH_MODE_IDE) ? 1'b0 : oeN_reg;

  // R16 no access before ready outside True IDE; one read word held at a time
  assign cmdReady = (state_reg == S_IDLE) & ~rdValid_reg;
  assign busy     = (state_reg != S_IDLE);
  assign legal    = opLegal(cmdOp, mode);

  // Device data strobe on iordy; either edge carries a word
  assign udCapture = (state_reg == S_URD) && (iordyS != iordyPrev_reg) && ackd_reg;

  // R8 pop only on the load phase; no word means no strobe edge
  assign fifoPop = (state_reg == S_UWR) & tick & ~phase_reg & (cnt_reg != 8'h00);

  // Main sequencer
  always @(posedge ref_clk) begin
    if (srst) begin
      state_reg     <= S_INIT;
      op_reg        <= `CFH_OP_OERD;
      cnt_reg       <= 8'h00;
      phase_reg     <= 1'b0;
      ackd_reg      <= 1'b0;
      csN_reg       <= 2'h3;
      iordN_reg     <= 1'b1;
      iowrN_reg     <= 1'b1;
      oeN_reg       <= 1'b1;
      dmackN_reg    <= 1'b1;
      dataOut_reg   <= 16'h0000;
      dataOeN_reg   <= 1'b1;
      rdData_reg    <= 16'h0000;
      rdValid_reg   <= 1'b0;
      cmdErr_reg    <= 1'b0;
      iordyPrev_reg <= 1'b0;
    end else begin
      cmdErr_reg    <= 1'b0;
      iordyPrev_reg <= iordyS;
      if (rdValid_reg && rdReady) begin
        rdValid_reg <= 1'b0;
      end
      case (state_reg)
        // R16 hold off until the card reports ready, or leave at once in True IDE
        S_INIT: begin
          if (readyS || mode == `CFH_MODE_IDE) begin
            state_reg <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (cmdValid && cmdReady) begin
            op_reg  <= cmdOp;
            cnt_reg <= cmdLen;
            if (!legal) begin
              // R21 refuse strobes the mode leaves unused
              cmdErr_reg <= 1'b1;
            end else if (cmdOp == `CFH_OP_UDRD || cmdOp == `CFH_OP_UDWR) begin
              // R2 chip selects stay negated for DMA
              csN_reg   <= 2'h3;
              state_reg <= S_DREQ;
            end else begin
              csN_reg   <= 2'h2;
              state_reg <= S_STB;
              // R12 R13 output enable read
              if (cmdOp == `CFH_OP_OERD) begin
                oeN_reg <= 1'b0;
              end
              // R4 R5 I/O read strobe
              if (cmdOp == `CFH_OP_IORD) begin
                iordN_reg <= 1'b0;
              end
              if (cmdOp == `CFH_OP_IOWR) begin
                iowrN_reg   <= 1'b0;
                dataOut_reg <= cmdWrData;
                dataOeN_reg <= 1'b0;
              end
            end
          end
        end
        S_STB: begin
          if (tick) begin
            // R9 rising edge while data still driven
            iowrN_reg <= 1'b1;
            iordN_reg <= 1'b1;
            oeN_reg   <= 1'b1;
            if (op_reg != `CFH_OP_IOWR) begin
              rdData_reg  <= dataS;
              rdValid_reg <= 1'b1;
            end
            state_reg <= S_TRAIL;
          end
        end
        S_TRAIL: begin
          if (tick) begin
            csN_reg     <= 2'h3;
            dataOeN_reg <= 1'b1;
            state_reg   <= S_IDLE;
          end
        end
        S_DREQ: begin
          // R10 write line negated while entering Ultra DMA
          iowrN_reg <= 1'b1;
          // R20 acknowledge once request is seen
          if (!ackd_reg && dmarqS) begin
            dmackN_reg <= 1'b0;
            ackd_reg   <= 1'b1;
          end else if (ackd_reg && tick) begin
            iowrN_reg <= 1'b0;
            phase_reg <= 1'b0;
            if (op_reg == `CFH_OP_UDWR) begin
              dataOeN_reg <= 1'b0;
              state_reg   <= S_UWR;
            end else begin
              state_reg <= S_URD;
            end
          end
        end
        S_URD: begin
          // R6 host-ready low only while a slot is free
          iordN_reg <= rdValid_reg | udCapture;
          if (udCapture) begin
            rdData_reg  <= dataS;
            rdValid_reg <= 1'b1;
            cnt_reg     <= cnt_reg - 8'h01;
          end
          if (cnt_reg == 8'h00) begin
            state_reg <= S_STOP;
          end
        end
        S_UWR: begin
          if (tick) begin
            if (phase_reg) begin
              // R2 full 16-bit word per strobe edge
              iordN_reg <= ~iordN_reg;
              cnt_reg   <= cnt_reg - 8'h01;
              phase_reg <= 1'b0;
            end else if (fifoPop && fifoValid) begin
              dataOut_reg <= fifoData;
              phase_reg   <= 1'b1;
            end else if (cnt_reg == 8'h00) begin
              state_reg <= S_STOP;
            end
          end
        end
        S_STOP: begin
          // R11 stop asserted ends the burst
          iowrN_reg <= 1'b1;
          if (tick) begin
            iordN_reg   <= 1'b1;
            dmackN_reg  <= 1'b1;
            ackd_reg    <= 1'b0;
            dataOeN_reg <= 1'b1;
            state_reg   <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Write data buffer; a full buffer stalls the source
  cfh_fifo #(
    .WIDTH (`CFH_BUS_W),
    .DEPTH (FIFO_D),
    .AW    (3)
  ) i_cfh_fifo (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .inData   (wrData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );
endmodule // cfh_host

`default_nettype wire

// File: verilog/cfh_regs.vh
// Purpose: Shared constants for the storage card host strobe controller
// Assumes: 10 MHz ref_clk; card pins synchronised inside the controller
// Notes:   Timing counts are derived from nanosecond figures
`ifndef CFH_REGS_VH
`define CFH_REGS_VH

// Clock period and least strobe width, in ns
`define CFH_CLK_NS   100
`define CFH_STB_NS   300
// Least time rounds up to whole cycles
`define CFH_STB_CYC  ((`CFH_STB_NS + `CFH_CLK_NS - 1) / `CFH_CLK_NS)

// Card operating modes
`define CFH_MODE_MEM 2'h0
`define CFH_MODE_IO  2'h1
`define CFH_MODE_IDE 2'h2

// Host command codes
`define CFH_OP_OERD  3'h0
`define CFH_OP_IORD  3'h1
`define CFH_OP_IOWR  3'h2
`define CFH_OP_UDRD  3'h3
`define CFH_OP_UDWR  3'h4

// Data bus width; every transfer uses all of it
`define CFH_BUS_W    16

`endif

// File: verilog/cfh_fifo.v
// Purpose: Small synchronous FIFO for the Ultra DMA write data path
// Assumes: One clock; push and pop follow valid/ready handshakes
// Notes:   Full and empty come straight from the occupancy count
`timescale 1ns/1ps
`default_nettype none

module cfh_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             srst,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_reg;
  reg [AW-1:0]    rdPtr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // Honest flags from the count
  assign inReady  = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage array, no reset needed
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always @(posedge ref_clk) begin
    if (srst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // cfh_fifo

`default_nettype wire

// File: sim/cfh_host_properties.sv
// Purpose: Port checks for the card host controller
// Assumes: Card pins pass two sync flops
// Notes:   Pin history needs two equal samples
`timescale 1ns/1ps
`default_nettype none
module cfh_host_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Command side
  input wire logic [1:0]  mode,
  input wire logic        cmdValid,
  input wire logic        cmdReady,
  input wire logic [2:0]  cmdOp,
  input wire logic        cmdErr_reg,
  input wire logic        cardReady,
  input wire logic        cardIrq,
  // Card pins
  input wire logic [1:0]  csN_reg,
  input wire logic        iordN_reg,
  input wire logic        iowrN_reg,
  input wire logic        oeN,
  input wire logic        dmackN_reg,
  input wire logic [15:0] dataOut_reg,
  input wire logic        dataOeN_reg,
  input wire logic        readyPin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_dma_cs_idle: assert property (!dmackN_reg |-> csN_reg == 2'h3)
    else $error("select active in DMA");
  a_ide_oe_low: assert property (mode == 2'h2 |-> !oeN)
    else $error("oe not low in IDE");
  a_io_write_edge: assert property (mode == 2'h1 && $fell(iowrN_reg) |->
    (!iowrN_reg && !dataOeN_reg)[*3] ##1 (iowrN_reg && !dataOeN_reg && $stable(dataOut_reg)))
    else $error("write strobe malformed");
  a_io_read_width: assert property (mode == 2'h1 && $fell(iordN_reg) |->
    (!iordN_reg && csN_reg == 2'h2)[*3] ##1 iordN_reg)
    else $error("read strobe malformed");
  a_stop_ends_burst: assert property (!dmackN_reg && $rose(iowrN_reg) |-> ##[1:4] dmackN_reg)
    else $error("burst not closed");
  a_udma_entry_negated: assert property ($fell(dmackN_reg) |-> iowrN_reg)
    else $error("write line low at entry");
  a_bad_op_error: assert property (cmdValid && cmdReady && cmdOp[2:1] != 2'h0
    && cmdOp != 3'h2 && mode != 2'h2 |-> ##[1:2] cmdErr_reg)
    else $error("illegal op not refused");
  a_mem_ready_track: assert property (mode == 2'h0 && $past(readyPin, 2) == $past(readyPin, 3)
    |-> cardReady == $past(readyPin, 2))
    else $error("ready mismatch");
  a_irq_polarity: assert property (mode[1] != mode[0] &&
    $past(readyPin, 2) == $past(readyPin, 3) |-> cardIrq == ($past(readyPin, 2) ^ mode[0]))
    else $error("irq polarity wrong");
endmodule // cfh_host_properties

bind cfh_host cfh_host_properties i_cfh_host_properties (.ref_clk, .srst, .mode, .cmdValid,
  .cmdReady, .cmdOp, .cmdErr_reg, .cardReady, .cardIrq, .csN_reg, .iordN_reg, .iowrN_reg,
  .oeN, .dmackN_reg, .dataOut_reg, .dataOeN_reg, .readyPin);
`default_nettype wire

// File: sim/cfh_card_model.sv
// Purpose: Behavioural card on the host pins
// Assumes: Mode given directly; short init
// Notes:   Released bus shows inverse of last word
`timescale 1ns/1ps
`default_nettype none
module cfh_card_model #(
  parameter logic [15:0] RD_WORD  = 16'h3c5a,
  parameter int          INIT_CYC = 40
) (
  // Clock, reset, controls
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [1:0]  mode,
  input  wire logic        irqReq,
  input  wire logic        dmaReq,
  // Host pins
  input  wire logic [1:0]  csN,
  input  wire logic        iordN,
  input  wire logic        iowrN,
  input  wire logic        oeN,
  input  wire logic        dmackN,
  input  wire logic [15:0] dataOut,
  input  wire logic        dataOeN,
  // Card pins
  output var  logic        readyPin,
  output var  logic        dmarqPin,
  output var  logic        iordyPin,
  output var  logic [15:0] dataIn
);
  logic [7:0]  initCnt;
  logic [3:0]  pace;
  logic [15:0] wrWord, lastWord, udWord;
  logic        iowrPrev, hsPrev;
  logic [15:0] capQ[$];
  wire         udma = !dmackN && !iowrN;
  wire         drv  = dataOeN && (udma || (!oeN && mode != 2'h2)
                      || (!iordN && csN != 2'h3 && mode != 2'h0 && dmackN));
  always_comb begin
    case (mode)
      2'h1: readyPin = (initCnt == 8'h0) && !irqReq;
      2'h2: readyPin = irqReq;
      default: readyPin = (initCnt == 8'h0);
    endcase
    dataIn = drv ? (udma ? udWord : RD_WORD) : ~lastWord;
  end
  // trailing write edge, both strobe edges
  always @(posedge ref_clk) begin
    iowrPrev <= iowrN;
    hsPrev   <= iordN;
    if (iowrN && !iowrPrev && csN != 2'h3 && mode != 2'h0) wrWord <= dataOut;
    if (udma && !dataOeN && iordN != hsPrev) capQ.push_back(dataOut);
  end
  // ready once init counts out; request until ack; words only while ready
  always @(posedge ref_clk) begin
    if (srst) begin
      initCnt  <= 8'(INIT_CYC);
      lastWord <= 16'h0;
      udWord   <= 16'h11ff;
      pace     <= 4'h0;
      iordyPin <= 1'b0;
      dmarqPin <= 1'b0;
    end else begin
      if (drv) lastWord <= dataIn;
      if (initCnt != 8'h0) initCnt <= initCnt - 8'h1;
      // request only when selected for DMA; a released line reads low
      dmarqPin <= dmaReq && dmackN && mode == 2'h2;
      if (udma && dataOeN && !iordN) begin
        pace <= pace + 4'h1;
        if (pace == 4'h7) udWord <= udWord + 16'h1;
        if (pace == 4'hf) iordyPin <= !iordyPin;
      end
    end
  end
endmodule // cfh_card_model
`default_nettype wire

// File: sim/cfh_host_bench.sv
// Purpose: Self-checking bench for the card host controller
// Assumes: Card model on the pins; rdReady held high
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "cfh_regs.vh"
module cfh_host_bench;
  localparam logic [15:0] RD_WORD = 16'h3c5a;
  logic        ref_clk = 1'b0, srst = 1'b1, cmdValid = 1'b0, wrValid = 1'b0;
  logic        rdReady = 1'b1, irqReq = 1'b0, dmaReq = 1'b0, errSeen = 1'b0;
  logic [1:0]  mode = `CFH_MODE_MEM;
  logic [2:0]  cmdOp = 3'h0;
  logic [7:0]  cmdLen = 8'h0;
  logic [15:0] cmdWrData = 16'h0, wrData = 16'h0;
  logic [15:0] rdQ[$];
  wire         cmdReady, cmdErr_reg, wrReady, rdValid_reg, busy, cardReady, cardIrq;
  wire         iordN_reg, iowrN_reg, oeN, dmackN_reg, dataOeN_reg, readyPin, dmarqPin, iordyPin;
  wire  [1:0]  csN_reg;
  wire  [15:0] rdData_reg, dataIn, dataOut_reg;
  int          n_fail = 0, checks = 0, cyc = 0, n = 0;

  always #50 ref_clk = ~ref_clk;

  cfh_host i_cfh_host (.ref_clk, .srst, .mode, .cmdValid, .cmdReady, .cmdOp, .cmdWrData,
    .cmdLen, .cmdErr_reg, .wrValid, .wrReady, .wrData, .rdValid_reg, .rdReady, .rdData_reg,
    .busy, .cardReady, .cardIrq, .csN_reg, .iordN_reg, .iowrN_reg, .oeN, .dmackN_reg,
    .dataIn, .dataOut_reg, .dataOeN_reg, .readyPin, .dmarqPin, .iordyPin);
  cfh_card_model #(.RD_WORD(RD_WORD)) i_cfh_card_model (.ref_clk, .srst, .mode, .irqReq,
    .dmaReq, .csN(csN_reg), .iordN(iordN_reg), .iowrN(iowrN_reg), .oeN, .dmackN(dmackN_reg),
    .dataOut(dataOut_reg), .dataOeN(dataOeN_reg), .readyPin, .dmarqPin, .iordyPin, .dataIn);

  // Collect words and errors; cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rdValid_reg === 1'b1) rdQ.push_back(rdData_reg);
    if (cmdErr_reg === 1'b1) errSeen <= 1'b1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command, then wait for idle; one more edge lets an error pulse land
  task automatic cmd(input logic [2:0] op, input logic [15:0] wd, input logic [7:0] len);
    int k;
    k = 0;
    @(negedge ref_clk);
    rdQ.delete();
    errSeen = 1'b0;
    cmdOp = op;
    cmdWrData = wd;
    cmdLen = len;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && k < 500) begin @(negedge ref_clk); k++; end
    @(negedge ref_clk);
    cmdValid = 1'b0;
    while ((busy !== 1'b0 || cmdReady !== 1'b1) && k < 2000) begin @(negedge ref_clk); k++; end
    @(negedge ref_clk);
  endtask

  // Push up to lim words while the buffer takes them
  task automatic fill(input logic [15:0] base, input int lim, output int cnt);
    cnt = 0;
    repeat (lim + 4) begin
      @(negedge ref_clk);
      wrValid = wrReady && cnt < lim;
      wrData = base + 16'(cnt);
      if (wrValid) cnt++;
    end
    @(negedge ref_clk);
    wrValid = 1'b0;
  endtask

  task automatic t_mem;
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk("ready early", 16'h0, 16'(cmdReady));
    chk("busy in init", 16'h1, 16'(busy));
    cmd(`CFH_OP_OERD, 16'h0, 8'h0);
    chk("card ready", 16'h1, 16'(cardReady));
    chk("oe read", RD_WORD, rdQ[0]);
    cmd(`CFH_OP_IORD, 16'h0, 8'h0);
    chk("iord in mem", 16'h1, 16'(errSeen));
  endtask

  task automatic t_io;
    mode = `CFH_MODE_IO;
    cmd(`CFH_OP_IOWR, 16'ha5c3, 8'h0);
    chk("io write", 16'ha5c3, i_cfh_card_model.wrWord);
    cmd(`CFH_OP_IORD, 16'h0, 8'h0);
    chk("io read", RD_WORD, rdQ[0]);
    cmd(`CFH_OP_OERD, 16'h0, 8'h0);
    chk("cis read", RD_WORD, rdQ[0]);
    cmd(`CFH_OP_UDRD, 16'h0, 8'h2);
    chk("udma in io", 16'h1, 16'(errSeen));
    irqReq = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("io irq", 16'h1, 16'(cardIrq));
    irqReq = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("io irq off", 16'h0, 16'(cardIrq));
  endtask

  task automatic t_ide;
    mode = `CFH_MODE_IDE;
    irqReq = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("ide irq", 16'h1, 16'(cardIrq));
    chk("oe grounded", 16'h0, 16'(oeN));
    irqReq = 1'b0;
    cmd(`CFH_OP_IORD, 16'h0, 8'h0);
    chk("ide io read", RD_WORD, rdQ[0]);
    fill(16'hc000, 12, n);
    chk("buffer depth", 16'h8, 16'(n));
    chk("buffer full", 16'h0, 16'(wrReady));
    dmaReq = 1'b1;
    fork
      cmd(`CFH_OP_UDWR, 16'h0, 8'ha);
      begin
        repeat (150) @(negedge ref_clk);
        fill(16'hc008, 2, n);
      end
    join
    chk("words out", 16'ha, 16'(i_cfh_card_model.capQ.size()));
    for (int k = 0; k < 10; k++) chk("word out", 16'hc000 + 16'(k), i_cfh_card_model.capQ[k]);
    cmd(`CFH_OP_UDRD, 16'h0, 8'h3);
    chk("words in", 16'h3, 16'(rdQ.size()));
    for (int k = 0; k < 3; k++) chk("word in", 16'h1200 + 16'(k), rdQ[k]);
  endtask

  initial begin
    t_mem;
    t_io;
    t_ide;
    report_and_stop;
  end
endmodule // cfh_host_bench
`default_nettype wire
